// ### rtl/itsr_div.sv
// divider chain giving the 1 Hz to 1024 Hz taps and the one-second tick
`timescale 1ns/100ps
`default_nettype none
module itsr_div
    import itsr_pkg::*;
#(
    parameter int unsigned TAP_CYCLES = 24414
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   ce_i,
    input  wire logic                   clr_i,
    output logic      [`ITSR_SEL_W-1:0] taps_o,
    output logic                        tick_o
);
    import itsr_pkg::*;

    itsr_div_s r;
    itsr_div_s next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (clr_i) begin
            next_r.pre = '0;
            next_r.cnt = '0;
        end else if (r.pre == 16'(TAP_CYCLES - 1)) begin
            next_r.pre  = '0;
            next_r.cnt  = r.cnt + 1'b1;
            next_r.tick = &r.cnt;
        end else begin
            next_r.pre = r.pre + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // bit 0 is the 1024 Hz tap; the inverse starts each tap in its high phase
    assign taps_o = ~r.cnt;
    assign tick_o = r.tick;
endmodule // itsr_div
`default_nettype wire

// ### rtl/itsr_pkg.sv
// types of the interval timer serial register block
`include "itsr_regs.svh"
package itsr_pkg;

    typedef enum logic [6:0] {
        ITSR_IDLE = 7'h01,
        ITSR_ADDR = 7'h02,
        ITSR_RX   = 7'h04,
        ITSR_ACK  = 7'h08,
        ITSR_TX   = 7'h10,
        ITSR_MACK = 7'h20,
        ITSR_SKIP = 7'h40
    } itsr_link_e;

    // setting handed from the link domain to the timer domain
    typedef struct packed {
        logic [`ITSR_SEL_W-1:0] sel;
        logic [2:0]             cmd;
        logic                   clr;
    } itsr_set_s;

    typedef struct packed {
        itsr_link_e  st;
        logic [3:0]  bits;
        logic [2:0]  byte_no;
        logic [7:0]  sh;
        logic [23:0] rbuf;
        logic        rd;
        logic        scl_q;
        logic        sda_q;
        logic        oe;
        logic        sda_out;
        itsr_set_s   set;
        logic        set_tgl;
        logic        cnt_seen;
        logic [23:0] cnt_copy;
    } itsr_link_s;

    typedef struct packed {
        logic [23:0]            count;
        logic                   cnt_tgl;
        logic                   set_seen;
        logic [`ITSR_SEL_W-1:0] sel;
        logic                   int_out;
    } itsr_core_s;

    typedef struct packed {
        logic [15:0]            pre;
        logic [`ITSR_SEL_W-1:0] cnt;
        logic                   tick;
    } itsr_div_s;

endpackage

// ### rtl/itsr_regs.svh
// constants of the interval timer serial register block
`ifndef ITSR_REGS_SVH
`define ITSR_REGS_SVH

`define ITSR_DEV_ADDR       7'h32
`define ITSR_CLR_PATTERN    3'h2
`define ITSR_CNT_MAX        24'hffffff
`define ITSR_CNT_RESET      24'h000000
`define ITSR_FILL_BYTE      8'hff
`define ITSR_SEL_RESET      11'h000
`define ITSR_CMD_RESET      3'h7
`define ITSR_FILLER_READ    2'h0
`define ITSR_SEL_W          11
`define ITSR_BITS_PER_BYTE  4'h8
`define ITSR_BYTE_ADDR      3'h1
`define ITSR_BYTE_SEL_HI    3'h3
`define ITSR_BYTE_SEL_LO    3'h4
`define ITSR_BYTE_LAST      3'h7
`define ITSR_CLK_PERIOD_NS  20
`define ITSR_TAP_PERIOD_NS  488281

`endif

// ### rtl/itsr_sync3.sv
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module itsr_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } itsr_sync_s;

    itsr_sync_s   r;
    itsr_sync_s   next_r;
    logic [W-1:0] agreed;

    // per bit: a level counts only when two settled stages agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign agreed[i] = (r.s2[i] == r.s3[i]) ? r.s3[i] : r.q[i];
    end

    always_comb begin
        next_r    = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = agreed;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule // itsr_sync3
`default_nettype wire

// ### rtl/itsr_top.sv
// two-wire slave, seconds counter and periodic output of the interval timer
`timescale 1ns/100ps
`default_nettype none
module itsr_top
    import itsr_pkg::*;
#(
    parameter int unsigned TAP_CYCLES = `ITSR_TAP_PERIOD_NS / `ITSR_CLK_PERIOD_NS
) (
    input  wire logic CLK_I,
    input  wire logic RESET_N_I,
    input  wire logic CE_I,
    input  wire logic LINK_CLK_I,
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE_O,
    input  wire logic OUTPUT_GATE_INPUT_I,
    output logic      INT_O
);
    import itsr_pkg::*;

    itsr_link_s lr;
    itsr_link_s next_lr;
    itsr_core_s cr;
    itsr_core_s next_cr;

    // link domain: pins and the count toggle from the timer domain
    logic       scl_low_f;
    logic       sda_low_f;
    logic       scl_f;
    logic       sda_f;
    logic       gate_l;
    logic       cnt_tgl_l;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] rx_byte;

    itsr_sync3 #(.W(4)) u_link_sync (
        .clk_i   (LINK_CLK_I),
        .rst_n_i (RESET_N_I),
        .ce_i    (CE_I),
        .d_i     ({~SCL_I, ~SDA_I, OUTPUT_GATE_INPUT_I, cr.cnt_tgl}),
        .q_o     ({scl_low_f, sda_low_f, gate_l, cnt_tgl_l})
    );

    // pins enter inverted so the cleared synchroniser shows an idle bus, no false edge
    assign scl_f   = ~scl_low_f;
    assign sda_f   = ~sda_low_f;

    assign rise    = scl_f & ~lr.scl_q;
    assign fall    = ~scl_f & lr.scl_q;
    assign start   = scl_f & lr.scl_q & lr.sda_q & ~sda_f;
    assign stop    = scl_f & lr.scl_q & ~lr.sda_q & sda_f;
    assign rx_byte = lr.sh;

    always_comb begin
        next_lr       = lr;
        next_lr.scl_q = scl_f;
        next_lr.sda_q = sda_f;
        // count word is stable for a whole tick once its toggle settles
        if (cnt_tgl_l != lr.cnt_seen) begin
            next_lr.cnt_seen = cnt_tgl_l;
            next_lr.cnt_copy = cr.count;
        end
        if (stop) begin
            next_lr.st = ITSR_IDLE;
            next_lr.oe = 1'b0;
        end else if (start) begin
            next_lr.st      = ITSR_ADDR;
            next_lr.bits    = '0;
            next_lr.byte_no = `ITSR_BYTE_ADDR;
            next_lr.oe      = 1'b0;
        end else begin
            case (lr.st)
                ITSR_ADDR, ITSR_RX: begin
                    if (rise && lr.bits != `ITSR_BITS_PER_BYTE) begin
                        next_lr.sh   = {lr.sh[6:0], sda_f};
                        next_lr.bits = lr.bits + 4'h1;
                    end else if (fall && lr.bits == `ITSR_BITS_PER_BYTE) begin
                        next_lr.bits = '0;
                        if (lr.byte_no != `ITSR_BYTE_LAST) begin
                            next_lr.byte_no = lr.byte_no + 3'h1;
                        end
                        if (lr.st == ITSR_ADDR) begin
                            if (rx_byte[7:1] == `ITSR_DEV_ADDR) begin
                                next_lr.rd = rx_byte[0];
                                next_lr.oe = 1'b1;
                                next_lr.st = ITSR_ACK;
                                // snapshot keeps the three count bytes coherent
                                if (gate_l) begin
                                    next_lr.rbuf = {lr.set.sel, `ITSR_FILLER_READ,
                                                    lr.set.cmd, `ITSR_FILL_BYTE};
                                end else begin
                                    next_lr.rbuf = lr.cnt_copy;
                                end
                            end else begin
                                next_lr.st = ITSR_SKIP;
                            end
                        end else begin
                            next_lr.oe = 1'b1;
                            next_lr.st = ITSR_ACK;
                            // the select high and select low bytes each take effect on their own
                            if (lr.byte_no == `ITSR_BYTE_SEL_HI) begin
                                next_lr.set.sel[10:3] = rx_byte;
                                next_lr.set.clr       = 1'b0;
                                next_lr.set_tgl       = ~lr.set_tgl;
                            end else if (lr.byte_no == `ITSR_BYTE_SEL_LO) begin
                                next_lr.set.sel[2:0] = rx_byte[7:5];
                                next_lr.set.cmd      = rx_byte[2:0];
                                next_lr.set.clr = (rx_byte[2:0] == `ITSR_CLR_PATTERN);
                                next_lr.set_tgl = ~lr.set_tgl;
                            end
                        end
                    end
                end
                ITSR_ACK: begin
                    if (fall) begin
                        if (lr.rd) begin
                            next_lr.st = ITSR_TX;
                            next_lr.oe = ~lr.rbuf[23];
                        end else begin
                            next_lr.st = ITSR_RX;
                            next_lr.oe = 1'b0;
                        end
                    end
                end
                ITSR_TX: begin
                    if (rise) begin
                        next_lr.bits = lr.bits + 4'h1;
                    end else if (fall) begin
                        next_lr.rbuf = {lr.rbuf[22:0], 1'b1};
                        if (lr.bits == `ITSR_BITS_PER_BYTE) begin
                            next_lr.bits = '0;
                            next_lr.oe   = 1'b0;
                            next_lr.st   = ITSR_MACK;
                        end else begin
                            next_lr.oe = ~lr.rbuf[22];
                        end
                    end
                end
                ITSR_MACK: begin
                    if (rise) begin
                        if (sda_f) begin
                            next_lr.st = ITSR_SKIP;
                        end else begin
                            next_lr.bits = 4'h1;
                        end
                    end else if (fall && lr.bits == 4'h1) begin
                        next_lr.bits = '0;
                        next_lr.st   = ITSR_TX;
                        next_lr.oe   = ~lr.rbuf[23];
                    end
                end
                ITSR_IDLE, ITSR_SKIP: begin
                    next_lr.oe = 1'b0;
                end
                default: begin
                    next_lr.st = ITSR_IDLE;
                    next_lr.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lr          <= '0;
            lr.st       <= ITSR_IDLE;
            lr.byte_no  <= `ITSR_BYTE_ADDR;
            lr.scl_q    <= 1'b1;
            lr.sda_q    <= 1'b1;
            lr.set.sel  <= `ITSR_SEL_RESET;
            lr.set.cmd  <= `ITSR_CMD_RESET;
        end else if (CE_I) begin
            lr <= next_lr;
        end
    end

    assign SDA_O    = lr.sda_out;
    assign SDA_OE_O = lr.oe;

    // timer domain
    logic                   gate_low_c;
    logic                   gate_c;
    logic                   set_tgl_c;
    logic                   set_evt;
    logic                   div_clr;
    logic                   tick;
    logic [`ITSR_SEL_W-1:0] taps;

    itsr_sync3 #(.W(2)) u_core_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .ce_i    (CE_I),
        .d_i     ({~OUTPUT_GATE_INPUT_I, lr.set_tgl}),
        .q_o     ({gate_low_c, set_tgl_c})
    );

    // gate reads as high out of reset, so no output pulse before the pin settles
    assign gate_c = ~gate_low_c;

    assign set_evt = (set_tgl_c != cr.set_seen);
    // restart only while the output is actually producing the waveform
    assign div_clr = set_evt & gate_c & (|cr.sel);

    itsr_div #(.TAP_CYCLES(TAP_CYCLES)) u_div (
        .clk_i   (CLK_I),
        .rst_n_i (RESET_N_I),
        .ce_i    (CE_I),
        .clr_i   (div_clr),
        .taps_o  (taps),
        .tick_o  (tick)
    );

    always_comb begin
        next_cr = cr;
        if (set_evt) begin
            next_cr.set_seen = set_tgl_c;
            next_cr.sel      = lr.set.sel;
            if (lr.set.clr) begin
                next_cr.count   = `ITSR_CNT_RESET;
                next_cr.cnt_tgl = ~cr.cnt_tgl;
            end
        end
        if (tick && cr.count != `ITSR_CNT_MAX && !(set_evt && lr.set.clr)) begin
            next_cr.count   = cr.count + 24'h000001;
            next_cr.cnt_tgl = ~cr.cnt_tgl;
        end
        if (!gate_c) begin
            next_cr.int_out = 1'b1;
        end else if (cr.sel == `ITSR_SEL_RESET) begin
            next_cr.int_out = 1'b0;
        end else begin
            next_cr.int_out = &(taps | ~cr.sel);
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cr <= '0;
        end else if (CE_I) begin
            cr <= next_cr;
        end
    end

    assign INT_O = cr.int_out;

    sequence s_byte_in;
        lr.st == ITSR_RX && fall && lr.bits == `ITSR_BITS_PER_BYTE && CE_I;
    endsequence

    sequence s_ack_end;
        lr.st == ITSR_ACK && fall && !lr.rd && !start && !stop && CE_I;
    endsequence

    chk_ack_drive: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
        s_byte_in |=> lr.st == ITSR_ACK && SDA_OE_O)
        else $error("no acknowledge after received byte");

    chk_ack_release: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
        s_ack_end |=> !SDA_OE_O && lr.st == ITSR_RX)
        else $error("data line held after acknowledge");

    chk_start_addr: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
        start && !stop && CE_I |=> lr.st == ITSR_ADDR && lr.bits == 4'h0)
        else $error("start not taken");

    chk_stop_idle: assert property (@(posedge LINK_CLK_I) disable iff (!RESET_N_I)
        stop && CE_I |=> lr.st == ITSR_IDLE && !SDA_OE_O)
        else $error("stop did not idle the link");

    chk_count_clear: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        set_evt && lr.set.clr && CE_I |=> cr.count == `ITSR_CNT_RESET)
        else $error("reset command did not clear count");

    chk_count_hold: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        set_evt && !lr.set.clr && !tick && CE_I |=> cr.count == $past(cr.count))
        else $error("setting write disturbed count");

    chk_count_sat: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        cr.count == `ITSR_CNT_MAX && !(set_evt && lr.set.clr) |=> cr.count == `ITSR_CNT_MAX)
        else $error("count left saturation");

    chk_int_gate: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        !gate_c && CE_I ##1 !gate_c && CE_I |=> INT_O)
        else $error("output not high while gate low");

    chk_int_zero: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
        gate_c && cr.sel == `ITSR_SEL_RESET && CE_I |=> !INT_O)
        else $error("output not low with no select");
endmodule // itsr_top
`default_nettype wire

// ### rtl/itsr_unused_placeholder_never.sv
// intentionally empty
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ### testbench/itsr_master_model.sv
// behavioural two-wire bus master driving the serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module itsr_master_model #(
    parameter int HALF = 40
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_low_o
);
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    // half a bit period; 800 ns keeps both clock phases above the eight link clocks needed
    task automatic half();
        repeat (HALF) @(negedge clk_i);
    endtask

    // also works as a repeated start, since data is only released while the clock is low
    task automatic start();
        sda_low_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b0;
    endtask

    task automatic stop();
        sda_low_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_low_o = 1'b0;
        half();
    endtask

    // data changes only in the low phase and is sampled at the end of the high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_low_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack_level);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, ack_level);
    endtask

    // acknowledge every byte except the last one of a read
    task automatic read_byte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(last, r);
    endtask
endmodule // itsr_master_model
`default_nettype wire

// ### testbench/itsr_tb_top.sv
// self-checking bench of the interval timer serial register block
`timescale 1ns/100ps
`default_nettype none
`include "itsr_regs.svh"
`define CHECK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end
module itsr_tb_top;
    import itsr_pkg::*;
    localparam int TAP = 4;
    localparam int SEC = 2048 * TAP;
    logic       CLK_I;
    logic       LINK_CLK_I;
    logic       RESET_N_I;
    logic       OUTPUT_GATE_INPUT_I;
    logic       SDA_O;
    logic       SDA_OE_O;
    logic       INT_O;
    wire        scl_w;
    wire        sda_low;
    wire        sda_w;
    int         errors;
    int         num_checks;
    logic [7:0] seed;
    time        t0;

    // open-drain wire with pull-up: low while either party pulls it
    assign sda_w = ~(sda_low | SDA_OE_O);

    itsr_top #(.TAP_CYCLES(TAP)) itsr_top_inst (
        .CLK_I      (CLK_I),
        .RESET_N_I  (RESET_N_I),
        .CE_I       (1'b1),
        .LINK_CLK_I (LINK_CLK_I),
        .SCL_I      (scl_w),
        .SDA_I      (sda_w),
        .SDA_O      (SDA_O),
        .SDA_OE_O   (SDA_OE_O),
        .OUTPUT_GATE_INPUT_I     (OUTPUT_GATE_INPUT_I),
        .INT_O      (INT_O)
    );

    itsr_master_model itsr_master_model_inst (
        .clk_i     (CLK_I),
        .sda_i     (sda_w),
        .scl_o     (scl_w),
        .sda_low_o (sda_low)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // whole seconds elapsed since t0, with one second of slack for the divider phase
    function automatic logic in_range(input logic [23:0] cnt, input time now);
        int e;
        e = int'((now - t0) / (20 * SEC));
        return (int'(cnt) + 1 >= e) && (int'(cnt) <= e + 1);
    endfunction

    task automatic send(input logic [7:0] d);
        logic a;
        itsr_master_model_inst.write_byte(d, a);
        `CHECK(a, 1'b0)
    endtask

    task automatic wr_set(input logic [10:0] sel, input logic [2:0] cmd);
        seed = lfsr(seed);
        itsr_master_model_inst.start();
        send({`ITSR_DEV_ADDR, 1'b0});
        send({seed[6:0], 1'b1});
        send(sel[10:3]);
        send({sel[2:0], seed[7:6], cmd});
        itsr_master_model_inst.stop();
    endtask

    task automatic rd(input int n, input logic restart, output logic [31:0] v);
        logic [7:0] d;
        itsr_master_model_inst.start();
        if (restart) begin
            send({`ITSR_DEV_ADDR, 1'b0});
            itsr_master_model_inst.start();
        end
        send({`ITSR_DEV_ADDR, 1'b1});
        v = '0;
        for (int i = 0; i < n; i++) begin
            itsr_master_model_inst.read_byte(d, i == n - 1);
            v = {v[23:0], d};
        end
        itsr_master_model_inst.stop();
    endtask

    task automatic count_rises(input int n, output int r);
        logic prev;
        r = 0;
        prev = INT_O;
        repeat (n) begin
            @(negedge CLK_I);
            if (INT_O === 1'b1 && prev === 1'b0) r++;
            prev = INT_O;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        CLK_I = 1'b0;
        forever #10 CLK_I = ~CLK_I;
    end

    // first rising edge lands inside the short reset so the link side is cleared
    initial begin
        LINK_CLK_I = 1'b0;
        #7;
        forever begin
            LINK_CLK_I = ~LINK_CLK_I;
            #40;
        end
    end

    // reset is asynchronous and spans two timer clocks and one link edge
    initial begin
        logic [31:0] v;
        logic [10:0] s;
        logic [2:0]  c;
        logic        a;
        int          r;
        int          e;
        errors = 0;
        num_checks = 0;
        seed = 8'h62;
        RESET_N_I = 1'b0;
        OUTPUT_GATE_INPUT_I = 1'b1;
        repeat (2) @(negedge CLK_I);
        RESET_N_I = 1'b1;
        repeat (40) @(negedge CLK_I);
        `CHECK(INT_O, 1'b0)
        `CHECK(SDA_OE_O, 1'b0)
        `CHECK(SDA_O, 1'b0)
        OUTPUT_GATE_INPUT_I = 1'b0;
        repeat (20) @(negedge CLK_I);
        `CHECK(INT_O, 1'b1)
        itsr_master_model_inst.start();
        itsr_master_model_inst.write_byte({7'h33, 1'b0}, a);
        `CHECK(a, 1'b1)
        itsr_master_model_inst.stop();
        wr_set(11'h000, 3'h2);
        t0 = $time;
        rd(4, 1'b0, v);
        `CHECK(v[31:8] <= 24'h000001, 1'b1)
        `CHECK(v[7:0], 8'hff)
        repeat (2 * SEC) @(negedge CLK_I);
        wr_set(11'h000, 3'h7);
        rd(3, 1'b0, v);
        `CHECK(in_range(v[23:0], $time), 1'b1)
        OUTPUT_GATE_INPUT_I = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            s[10:8] = seed[2:0];
            seed = lfsr(seed);
            s[7:0] = seed;
            c = (i == 0) ? 3'h2 : seed[5:3];
            wr_set(s, c);
            rd(3, 1'b1, v);
            `CHECK(v[23:0], {s[10:3], s[2:0], 2'h0, c, 8'hff})
        end
        for (int k = 1; k <= 3; k++) begin
            wr_set(11'((1 << k) - 1), 3'h7);
            repeat (50) @(negedge CLK_I);
            count_rises(800, r);
            e = 800 / ((2 * TAP) << (k - 1));
            `CHECK((r + 1 >= e) && (r <= e + 1), 1'b1)
        end
        end_sim();
    end

    // the full sequence needs roughly 71000 cycles
    initial begin
        repeat (95000) @(posedge CLK_I);
        errors++;
        end_sim();
    end
endmodule // itsr_tb_top
`default_nettype wire
